// ===== ssra_regs.svh
// timing constants and pin counts for the strobed static ram controller
`ifndef SSRA_REGS_SVH
`define SSRA_REGS_SVH
`define SSRA_CLK_PERIOD_NS      8
`define SSRA_INDEX_W            12
`define SSRA_ACCESS_DELAY_NS    200
`define SSRA_INDEX_HOLD_NS      110
`define SSRA_DIN_HOLD_SEL_NS    170
`define SSRA_DIN_HOLD_WR_NS     70
`define SSRA_WE_PULSE_NS        60
`define SSRA_WE_LEAD_NS         70
`define SSRA_WRITE_HOLD_NS      150
`define SSRA_RMW_CYCLE_NS       385
`define SSRA_SEL_PULSE_NS       200
`define SSRA_SEL_PRECHARGE_NS   100
`define SSRA_PPD_NS             100
`define SSRA_RECOVERY_US        500
`define SSRA_POWERUP_US         2000
`define SSRA_MODIFY_MAX_NS      10000
// least times round up to whole cycles
`define SSRA_CYC(ns) (((ns) + `SSRA_CLK_PERIOD_NS - 1) / `SSRA_CLK_PERIOD_NS)
`define SSRA_ACCESS_CYC     `SSRA_CYC(`SSRA_ACCESS_DELAY_NS)
`define SSRA_DIN_HOLD_CYC   `SSRA_CYC(`SSRA_DIN_HOLD_SEL_NS)
`define SSRA_WE_PULSE_CYC   `SSRA_CYC(`SSRA_WE_PULSE_NS)
`define SSRA_WE_LEAD_CYC    `SSRA_CYC(`SSRA_WE_LEAD_NS)
`define SSRA_WRITE_HOLD_CYC `SSRA_CYC(`SSRA_WRITE_HOLD_NS)
`define SSRA_SEL_PULSE_CYC  `SSRA_CYC(`SSRA_SEL_PULSE_NS)
`define SSRA_PRECHARGE_CYC  `SSRA_CYC(`SSRA_SEL_PRECHARGE_NS)
`define SSRA_PPD_CYC        `SSRA_CYC(`SSRA_PPD_NS)
`define SSRA_RMW_CYC        `SSRA_CYC(`SSRA_RMW_CYCLE_NS)
// longest time rounds down
`define SSRA_MODIFY_MAX_CYC (`SSRA_MODIFY_MAX_NS / `SSRA_CLK_PERIOD_NS)
`endif

// ===== ssra_pkg.sv
// types for the strobed static ram controller
package ssra_pkg;
  typedef enum logic [1:0] {
    SSRA_READ,
    SSRA_WRITE,
    SSRA_RMW
  } ssra_op_t;

  typedef struct packed {
    ssra_op_t    op;
    logic [11:0] index;
    logic        wrData;
  } ssra_req_t;

  typedef struct packed {
    logic [11:0] cellIndex;
    logic        selectN;
    logic        writeN;
    logic        dataIn;
  } ssra_pins_t;
endpackage

// ===== ssra_ctrl.sv
// host controller driving a strobed 4096x1 static ram through its pins
`timescale 1ns/100ps
`include "ssra_regs.svh"

module ssra_ctrl #(
  parameter int unsigned POWERUP_CYC  = `SSRA_POWERUP_US * 1000 / 8,
  parameter int unsigned RECOVERY_CYC = `SSRA_RECOVERY_US * 1000 / 8
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  // user request
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire ssra_pkg::ssra_req_t req,
  input  wire logic [13:0]       modifyCyc,
  output logic                   rdValid,
  output logic                   rdData,
  // power sequencing
  input  wire logic              powerDownReq,
  output logic                   powerDownOk,
  // memory pins
  output ssra_pkg::ssra_pins_t   pins,
  input  wire logic              dataOut
);
  typedef enum logic [2:0] {
    S_PWRUP, S_IDLE, S_ACTIVE, S_PRECH, S_PPD, S_DOWN, S_RECOV
  } ssra_state_t;

  localparam int unsigned ACC  = `SSRA_ACCESS_CYC;
  localparam int unsigned SELW = `SSRA_SEL_PULSE_CYC;
  localparam int unsigned WLD  = `SSRA_WE_LEAD_CYC;
  localparam int unsigned WPW  = `SSRA_WE_PULSE_CYC;
  localparam int unsigned WHLD = `SSRA_WRITE_HOLD_CYC;
  localparam int unsigned DHLD = `SSRA_DIN_HOLD_CYC;
  localparam int unsigned PRE  = `SSRA_PRECHARGE_CYC;
  localparam int unsigned PPD  = `SSRA_PPD_CYC;
  localparam int unsigned MODM = `SSRA_MODIFY_MAX_CYC;
  // the read bit is taken two cycles after access, behind the synchroniser,
  // so reads hold select past its minimum to keep the output driven
  localparam int unsigned RDS  = ACC + 2;
  localparam int unsigned MODC = MODM - RDS - 1 - WLD;

  ssra_state_t         state_q, state_d;
  logic [19:0]         cnt_q, cnt_d;
  logic [19:0]         len_q, len_d;
  logic [19:0]         weAt_q, weAt_d;
  ssra_pkg::ssra_op_t  op_q, op_d;
  ssra_pkg::ssra_pins_t pins_q, pins_d;
  logic                rdValid_q, rdValid_d;
  logic                rdData_q, rdData_d;
  logic                doSync1_q, doSync2_q;
  logic                pdSync1_q, pdSync2_q;
  logic [13:0]         modClip;
  logic [11:0]         selRun_q, selRun_d;

  // clip so the select pulse never exceeds its maximum
  assign modClip = (32'(modifyCyc) > MODC)
                   ? 14'(MODC) : modifyCyc;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q + 20'h00001;
    len_d     = len_q;
    weAt_d    = weAt_q;
    op_d      = op_q;
    pins_d    = pins_q;
    rdValid_d = 1'b0;
    rdData_d  = rdData_q;
    case (state_q)
      S_PWRUP: begin
        pins_d.selectN = 1'b1;
        pins_d.writeN  = 1'b1;
        if (cnt_q >= 20'(POWERUP_CYC)) begin
          state_d = S_IDLE;
        end
      end
      S_IDLE: begin
        cnt_d = 20'h00000;
        if (pdSync2_q) begin
          state_d = S_PPD;
        end else if (reqValid) begin
          op_d             = req.op;
          pins_d.cellIndex = req.index;
          pins_d.dataIn    = req.wrData;
          pins_d.selectN   = 1'b0;
          if (req.op == ssra_pkg::SSRA_WRITE) begin
            pins_d.writeN = 1'b0;
            weAt_d        = 20'h00000;
            len_d         = 20'(SELW > DHLD ? SELW : DHLD);
          end else if (req.op == ssra_pkg::SSRA_RMW) begin
            pins_d.writeN = 1'b1;
            weAt_d        = 20'(RDS) + 20'(modClip);
            len_d         = weAt_d + 20'(WLD + 1);
          end else begin
            pins_d.writeN = 1'b1;
            weAt_d        = 20'hfffff;
            len_d         = 20'(RDS + 1);
          end
          state_d = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        if (cnt_q == weAt_q) begin
          pins_d.writeN = 1'b0;
        end
        if (cnt_q == 20'(RDS) && op_q != ssra_pkg::SSRA_WRITE) begin
          rdValid_d = 1'b1;
          rdData_d  = doSync2_q;
        end
        // index and data stay put for the whole pulse, covering all holds
        if (cnt_q + 20'h00001 >= len_q && cnt_q + 20'h00001 >= 20'(SELW)
            && (weAt_q == 20'hfffff
                || (cnt_q + 20'h00001 >= weAt_q + 20'(WPW)
                    && cnt_q + 20'h00001 >= 20'(WHLD)))) begin
          pins_d.selectN = 1'b1;
          pins_d.writeN  = 1'b1;
          cnt_d          = 20'h00000;
          state_d        = S_PRECH;
        end
      end
      S_PRECH: begin
        if (cnt_q + 20'h00001 >= 20'(PRE)) begin
          cnt_d   = 20'h00000;
          state_d = S_IDLE;
        end
      end
      S_PPD: begin
        if (cnt_q + 20'h00001 >= 20'(PPD)) begin
          state_d = S_DOWN;
        end
      end
      S_DOWN: begin
        cnt_d = 20'h00000;
        if (!pdSync2_q) begin
          state_d = S_RECOV;
        end
      end
      S_RECOV: begin
        if (cnt_q >= 20'(RECOVERY_CYC)) begin
          cnt_d   = 20'h00000;
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_PWRUP;
      end
    endcase
  end

  // enabled cycles since select last moved, for the pulse width checks
  always_comb begin
    selRun_d = (selRun_q == 12'hfff) ? selRun_q : selRun_q + 12'h001;
    if (pins_d.selectN != pins_q.selectN) begin
      selRun_d = 12'h000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q   <= S_PWRUP;
      cnt_q     <= 20'h00000;
      len_q     <= 20'h00000;
      weAt_q    <= 20'hfffff;
      op_q      <= ssra_pkg::SSRA_READ;
      pins_q    <= '{cellIndex: 12'h000, selectN: 1'b1, writeN: 1'b1,
                     dataIn: 1'b0};
      rdValid_q <= 1'b0;
      rdData_q  <= 1'b0;
      doSync1_q <= 1'b0;
      doSync2_q <= 1'b0;
      pdSync1_q <= 1'b0;
      pdSync2_q <= 1'b0;
      selRun_q  <= 12'h000;
    end else if (clkEn) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      len_q     <= len_d;
      weAt_q    <= weAt_d;
      op_q      <= op_d;
      pins_q    <= pins_d;
      rdValid_q <= rdValid_d;
      rdData_q  <= rdData_d;
      doSync1_q <= dataOut;
      doSync2_q <= doSync1_q;
      pdSync1_q <= powerDownReq;
      pdSync2_q <= pdSync1_q;
      selRun_q  <= selRun_d;
    end
  end

  // only reqReady and powerDownOk are combinational, every data output is a flop
  assign pins        = pins_q;
  assign reqReady    = (state_q == S_IDLE) && !pdSync2_q && clkEn;
  assign rdValid     = rdValid_q;
  assign rdData      = rdData_q;
  assign powerDownOk = (state_q == S_DOWN);

  a_read_we_high: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == S_ACTIVE && op_q == ssra_pkg::SSRA_READ)
    |-> pins_q.writeN) else $error("write strobe low in read");
  a_index_stable: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == S_ACTIVE && $past(state_q) == S_ACTIVE)
    |-> $stable(pins_q.cellIndex)) else $error("index moved");
  a_data_stable: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == S_ACTIVE && $past(state_q) == S_ACTIVE)
    |-> $stable(pins_q.dataIn)) else $error("data moved");
  a_early_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(pins_q.selectN) && op_q == ssra_pkg::SSRA_WRITE
    |-> !pins_q.writeN) else $error("early write late");
  a_sel_min: assert property (
    @(posedge ref_clk) disable iff (rst || !clkEn)
    $fell(pins_q.selectN) |-> !pins_q.selectN [*8])
    else $error("select pulse short");
  a_sel_width: assert property (
    @(posedge ref_clk) disable iff (rst || !clkEn)
    !pins_q.selectN && pins_d.selectN
    |-> selRun_q >= 12'(SELW - 1) && selRun_q <= 12'(MODM - 1))
    else $error("select pulse out of range");
  a_prech_min: assert property (
    @(posedge ref_clk) disable iff (rst || !clkEn)
    $rose(pins_q.selectN) |-> pins_q.selectN [*8])
    else $error("precharge short");
  a_prech_width: assert property (
    @(posedge ref_clk) disable iff (rst || !clkEn)
    pins_q.selectN && !pins_d.selectN |-> selRun_q >= 12'(PRE - 1))
    else $error("precharge too short");
  a_down_high: assert property (
    @(posedge ref_clk) disable iff (rst)
    (state_q == S_DOWN || state_q == S_RECOV || state_q == S_PPD)
    |-> pins_q.selectN) else $error("select low in standby");
  a_pwrup_high: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_q == S_PWRUP |-> pins_q.selectN && pins_q.writeN)
    else $error("strobe low at power up");
  a_we_lead: assert property (
    @(posedge ref_clk) disable iff (rst || !clkEn)
    $rose(pins_q.selectN) && op_q != ssra_pkg::SSRA_READ
    |-> !$past(pins_q.writeN, 8)) else $error("write lead short");
endmodule

// ===== ssra_mem_model.sv
// behavioural 4096x1 strobed static memory facing the controller
`timescale 1ns/100ps
`include "ssra_regs.svh"
module ssra_mem_model #(
  parameter int ACCESS_NS = `SSRA_ACCESS_DELAY_NS
) (
  // clock for the floating pattern
  input  wire logic                 ref_clk,
  // memory pins
  input  wire ssra_pkg::ssra_pins_t pins,
  output logic                      dataOut
);
  logic        cells [4096];
  logic [11:0] idx;
  logic        early;
  logic        driven;
  logic        flt;
  logic        selSeen;
  realtime     fallT;
  initial begin
    foreach (cells[i]) cells[i] = 1'b0;
    driven = 1'b0;
    flt = 1'b0;
    selSeen = 1'b0;
    fallT = 0;
  end
  always @(negedge pins.selectN) begin
    idx = pins.cellIndex;
    fallT = $realtime;
    early = !pins.writeN;
    selSeen = 1'b1;
    if (early) cells[idx] = pins.dataIn;
  end
  // a same-time strobe is left to the select edge to avoid a race
  always @(negedge pins.writeN) begin
    if (!pins.selectN && selSeen && $realtime > fallT) begin
      cells[idx] = pins.dataIn;
    end
  end
  always @(negedge pins.selectN) begin
    #(ACCESS_NS);
    if (!pins.selectN && !early) driven = 1'b1;
  end
  always @(posedge pins.selectN) begin
    driven = 1'b0;
    selSeen = 1'b0;
  end
  // an undriven output shows a changing pattern, never the last bit
  always @(posedge ref_clk) flt <= ~flt;
  assign dataOut = driven ? cells[idx] : flt;
endmodule

// ===== testbench.sv
// self-checking bench for the strobed static ram controller
`timescale 1ns/100ps
module testbench;
  localparam int PUP = 50;
  localparam int REC = 20;
  logic                 ref_clk, rst, clkEn, reqValid, powerDownReq;
  logic                 reqReady, rdValid, rdData, powerDownOk, dataOut;
  logic [13:0]          modifyCyc;
  ssra_pkg::ssra_req_t  req;
  ssra_pkg::ssra_pins_t pins;
  ssra_pkg::ssra_pins_t held;
  int                   fails, total_checks, seed, n, k;
  bit                   refMem [4096];
  ssra_ctrl #(.POWERUP_CYC(PUP), .RECOVERY_CYC(REC)) uut (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .modifyCyc(modifyCyc),
    .rdValid(rdValid), .rdData(rdData), .powerDownReq(powerDownReq),
    .powerDownOk(powerDownOk), .pins(pins), .dataOut(dataOut));
  ssra_mem_model mem (.ref_clk(ref_clk), .pins(pins), .dataOut(dataOut));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic doOp(input ssra_pkg::ssra_op_t op, input logic [11:0] i,
                      input logic d, input logic [13:0] m);
    int w;
    int low;
    int lo;
    bit rd;
    w = 0;
    // select already fell at the accepting edge, before the first count
    low = 1;
    rd = 0;
    while (reqReady !== 1'b1 && w < 2000) begin
      @(negedge ref_clk);
      w++;
    end
    check(w < 2000, 1);
    reqValid = 1'b1;
    req = '{op, i, d};
    modifyCyc = m;
    @(negedge ref_clk);
    reqValid = 1'b0;
    @(negedge ref_clk);
    check({pins.selectN, pins.writeN, pins.cellIndex},
          {1'b0, op != ssra_pkg::SSRA_WRITE, i});
    if (op == ssra_pkg::SSRA_WRITE) check(pins.dataIn, d);
    while ((pins.selectN === 1'b0 || (op != ssra_pkg::SSRA_WRITE && !rd))
           && w < 3000) begin
      if (rdValid === 1'b1) begin
        rd = 1;
        check(rdData, refMem[i]);
      end
      if (pins.selectN === 1'b0) low++;
      w++;
      @(negedge ref_clk);
    end
    check(rd, op != ssra_pkg::SSRA_WRITE);
    // a long modify time is trimmed so select stays under its maximum
    lo = (m > 14'h04c0) ? 1216 : m;
    check(low >= (op == ssra_pkg::SSRA_RMW ? 34 + lo : 25) && low <= 1250,
          1);
    if (op != ssra_pkg::SSRA_READ) refMem[i] = d;
  endtask
  initial begin
    seed = 5;
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    clkEn = 1'b1;
    reqValid = 1'b0;
    powerDownReq = 1'b0;
    req = '0;
    modifyCyc = 14'h0000;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (PUP - 5) begin
      @(negedge ref_clk);
      check({reqReady, pins.selectN, pins.writeN}, 3'h3);
    end
    doOp(ssra_pkg::SSRA_WRITE, 12'h000, 1'b1, 14'h0000);
    doOp(ssra_pkg::SSRA_WRITE, 12'hfff, 1'b1, 14'h0000);
    doOp(ssra_pkg::SSRA_READ, 12'hfff, 1'b0, 14'h0000);
    doOp(ssra_pkg::SSRA_RMW, 12'h000, 1'b0, 14'h0000);
    doOp(ssra_pkg::SSRA_READ, 12'h000, 1'b0, 14'h0000);
    for (k = 0; k < 40; k++) begin
      n = $unsigned($random(seed)) % 3;
      doOp(ssra_pkg::ssra_op_t'(n), 12'($random(seed)) & 12'h00f,
           1'($random(seed)), 14'($unsigned($random(seed)) % 16));
    end
    doOp(ssra_pkg::SSRA_RMW, 12'h00a, 1'b1, 14'h3fff);
    // a low clock enable in mid-read must freeze every pin
    fork
      doOp(ssra_pkg::SSRA_READ, 12'h00a, 1'b0, 14'h0000);
      begin
        while (pins.selectN !== 1'b0) @(negedge ref_clk);
        repeat (10) @(negedge ref_clk);
        held = pins;
        clkEn = 1'b0;
        repeat (2 + $unsigned($random(seed)) % 6) begin
          @(negedge ref_clk);
          check(pins, held);
        end
        clkEn = 1'b1;
      end
    join
    // power down requested in mid-cycle must let the cycle finish
    fork
      doOp(ssra_pkg::SSRA_WRITE, 12'h005, 1'b1, 14'h0000);
      begin
        while (pins.selectN !== 1'b0) @(negedge ref_clk);
        repeat (8) @(negedge ref_clk);
        powerDownReq = 1'b1;
      end
    join
    n = 0;
    while (powerDownOk !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    check({powerDownOk, pins.selectN, reqReady}, 3'h6);
    repeat (30) begin
      @(negedge ref_clk);
      check({powerDownOk, pins.selectN}, 2'h3);
    end
    powerDownReq = 1'b0;
    n = 0;
    while (reqReady !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      check(pins.selectN, 1);
      n++;
    end
    check(n >= REC && n < 500, 1);
    doOp(ssra_pkg::SSRA_READ, 12'h005, 1'b0, 14'h0000);
    doOp(ssra_pkg::SSRA_RMW, 12'h005, 1'b0, 14'h0007);
    doOp(ssra_pkg::SSRA_READ, 12'h005, 1'b0, 14'h0000);
    summarize();
  end
  // about 3700 cycles are needed, so this leaves a wide margin
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule
